// File: dpfd_decode.sv
// DRAM pin function decoder: command, address, mask, termination, strobe
//
// Summary of operation
// - masked write beats are discarded
// - mask sampled on both strobe edges
// - mode register one bit 11 picks mask
// - bank select names the target bank
// - bank select picks mode register on set
// - bit 10 on access requests auto precharge
// - bit 10 on precharge closes all banks
// - address gives row or start column
// - address carries mode register op-code
// - bit 12 high full burst, low chop
// - termination control enables pin termination
// - termination ignored when both registers disable
// - termination strobe terminated like data strobe
// - bit 11 zero means mask, strobe unused
// - reset is active low, synchronous to the system clock
// - read strobe edge aligned with data
// - strobe always a differential pair
// - no termination on input-only pins
// - chip select high masks all commands
`timescale 1ns/1ps
`default_nettype none
module dpfd_decode
  import dpfd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_ck,
  input wire logic i_dram_reset_n,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [DPFD_BANK_W-1:0] i_bank_select,
  input wire logic [DPFD_ADDR_W-1:0] i_addr,
  input wire logic i_termination_control,
  input wire logic i_dqs,
  input wire logic i_dqs_n,
  input wire logic [DPFD_DQ_W-1:0] i_dq,
  input wire logic i_write_byte_mask,
  input wire logic i_wr_out_ready,
  output logic o_wr_out_valid,
  output logic [DPFD_DQ_W-1:0] o_wr_out_data,
  output logic [DPFD_COL_W-1:0] o_wr_out_col,
  output logic [DPFD_BANK_W-1:0] o_wr_out_bank,
  input wire logic [DPFD_DQ_W-1:0] i_rd_data,
  output logic o_rd_data_ready,
  output logic [DPFD_DQ_W-1:0] o_dq_out,
  output logic o_dq_oe,
  output logic o_dqs_out,
  output logic o_dqs_n_out,
  output logic o_dqs_oe,
  output logic o_odt_dq_en,
  output logic o_odt_dqs_en,
  output logic o_odt_mask_en,
  output logic o_odt_termination_strobe_n_en,
  output logic o_termination_strobe_mode,
  output logic [DPFD_NBANK-1:0] o_bank_open,
  output logic [DPFD_ADDR_W-1:0] o_open_row [DPFD_NBANK],
  output logic [DPFD_ADDR_W-1:0] o_mode_register_one,
  output logic [DPFD_ADDR_W-1:0] o_mode_register_two,
  output logic [DPFD_ADDR_W-1:0] o_mode_register_other,
  output logic o_burst_chop,
  output logic o_auto_precharge,
  output logic o_busy
);
  // Two-stage synchronisers for all pins
  localparam int SW = 8 + DPFD_BANK_W + DPFD_ADDR_W + DPFD_DQ_W;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  logic ck_d_reg;
  logic dqs_d_reg;
  logic rst_n_s;
  logic cke_s;
  logic cs_n_s;
  logic ras_n_s;
  logic cas_n_s;
  logic we_n_s;
  logic odt_s;
  logic ck_s;
  logic dqs_s;
  logic dqs_n_s;
  logic mask_s;
  logic [DPFD_BANK_W-1:0] ba_s;
  logic [DPFD_ADDR_W-1:0] a_s;
  logic [DPFD_DQ_W-1:0] dq_s;

  assign pin_raw = {i_dram_reset_n, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n,
    i_termination_control, i_ck, i_bank_select, i_addr, i_dq};
  // Strobe pair and mask share a separate pair of stages
  logic [2:0] st1_reg;
  logic [2:0] st2_reg;

  // Synchroniser stages
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      st1_reg <= '0;
      st2_reg <= '0;
    end else if (i_ce) begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      st1_reg <= {i_dqs, i_dqs_n, i_write_byte_mask};
      st2_reg <= st1_reg;
    end
  end

  assign {rst_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, ck_s,
    ba_s, a_s, dq_s} = s2_reg;
  assign {dqs_s, dqs_n_s, mask_s} = st2_reg;

  // Edge detection of the link clock and data strobe
  logic ck_rise;
  logic dqs_edge;
  logic dqs_diff_ok;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ck_d_reg <= 1'b0;
      dqs_d_reg <= 1'b0;
    end else if (i_ce) begin
      ck_d_reg <= ck_s;
      dqs_d_reg <= dqs_s;
    end
  end
  assign ck_rise = ck_s && !ck_d_reg;
  assign dqs_diff_ok = (dqs_s != dqs_n_s);
  assign dqs_edge = (dqs_s != dqs_d_reg) && dqs_diff_ok;

  // Command decode on the rising link clock edge
  dpfd_cmd_t cmd;
  logic dev_on;
  assign dev_on = rst_n_s && cke_s;
  always_comb begin
    cmd = DPFD_CMD_NONE;
    if (ck_rise && dev_on && !cs_n_s) begin
      unique case ({ras_n_s, cas_n_s, we_n_s})
        DPFD_CODE_MRS: cmd = DPFD_CMD_MRS;
        DPFD_CODE_REF: cmd = DPFD_CMD_REF;
        DPFD_CODE_PRE: cmd = DPFD_CMD_PRE;
        DPFD_CODE_ACT: cmd = DPFD_CMD_ACT;
        DPFD_CODE_WR: cmd = DPFD_CMD_WR;
        DPFD_CODE_RD: cmd = DPFD_CMD_RD;
        DPFD_CODE_ZQ: cmd = DPFD_CMD_ZQ;
        DPFD_CODE_NOP: cmd = DPFD_CMD_NOP;
      endcase
    end
  end

  // Mode registers, loaded by the set command
  logic [DPFD_ADDR_W-1:0] mr1_reg;
  logic [DPFD_ADDR_W-1:0] mr2_reg;
  logic [DPFD_ADDR_W-1:0] mro_reg;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || (i_ce && !rst_n_s)) begin
      mr1_reg <= DPFD_MR_RESET;
      mr2_reg <= DPFD_MR_RESET;
      mro_reg <= DPFD_MR_RESET;
    end else if (i_ce && cmd == DPFD_CMD_MRS) begin
      unique case (ba_s)
        DPFD_MR1_SEL: mr1_reg <= a_s;
        DPFD_MR2_SEL: mr2_reg <= a_s;
        default: mro_reg <= a_s;
      endcase
    end
  end

  // Bank state: open flags and open rows
  logic [DPFD_NBANK-1:0] open_reg;
  logic [DPFD_ADDR_W-1:0] row_reg [DPFD_NBANK];
  logic ap_pend_reg;
  logic [DPFD_BANK_W-1:0] ap_bank_reg;
  logic burst_done;
  genvar gb;
  generate
    for (gb = 0; gb < DPFD_NBANK; gb++) begin : g_bank
      always_ff @(posedge i_clk) begin
        if (!i_reset_n || (i_ce && !rst_n_s)) begin
          open_reg[gb] <= 1'b0;
          row_reg[gb] <= '0;
        end else if (i_ce) begin
          if (cmd == DPFD_CMD_ACT && ba_s == DPFD_BANK_W'(gb)) begin
            open_reg[gb] <= 1'b1;
            row_reg[gb] <= a_s;
          end else if (cmd == DPFD_CMD_PRE &&
              (a_s[DPFD_AP_BIT] || ba_s == DPFD_BANK_W'(gb))) begin
            open_reg[gb] <= 1'b0;
          end else if (burst_done && ap_pend_reg &&
              ap_bank_reg == DPFD_BANK_W'(gb)) begin
            open_reg[gb] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Burst sequencer for reads and writes
  dpfd_state_t state_reg;
  logic [3:0] beats_reg;
  logic [DPFD_COL_W-1:0] col_reg;
  logic [DPFD_BANK_W-1:0] bank_reg;
  logic chop_reg;
  logic [3:0] beat_goal;
  logic beat_step;
  assign beat_goal = chop_reg ? DPFD_BEATS_CHOP : DPFD_BEATS_FULL;
  // Reads step on link clock or strobe, writes on strobe only
  assign beat_step = (state_reg == DPFD_RBURST) ? (ck_rise || dqs_edge) :
    dqs_edge;
  assign burst_done = (state_reg != DPFD_IDLE) && beat_step &&
    (beats_reg + 4'h1 == beat_goal);
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || (i_ce && !rst_n_s)) begin
      state_reg <= DPFD_IDLE;
      beats_reg <= '0;
      col_reg <= '0;
      bank_reg <= '0;
      chop_reg <= 1'b0;
      ap_pend_reg <= 1'b0;
      ap_bank_reg <= '0;
    end else if (i_ce) begin
      unique case (state_reg)
        DPFD_IDLE: begin
          if (cmd == DPFD_CMD_WR || cmd == DPFD_CMD_RD) begin
            state_reg <= (cmd == DPFD_CMD_WR) ? DPFD_WBURST : DPFD_RBURST;
            beats_reg <= '0;
            col_reg <= a_s[DPFD_COL_W-1:0];
            bank_reg <= ba_s;
            chop_reg <= !a_s[DPFD_BC_BIT];
            ap_pend_reg <= a_s[DPFD_AP_BIT];
            ap_bank_reg <= ba_s;
          end
        end
        DPFD_WBURST, DPFD_RBURST: begin
          if (beat_step) begin
            beats_reg <= beats_reg + 4'h1;
            if (beats_reg + 4'h1 == beat_goal) begin
              state_reg <= DPFD_IDLE;
              ap_pend_reg <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Write beats enter the FIFO unless masked
  logic termination_strobe_en;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  // Bank and start column travel with each beat through the FIFO
  localparam int FW = DPFD_FIFO_W + DPFD_COL_W + DPFD_BANK_W;
  logic [FW-1:0] fifo_out;
  assign termination_strobe_en = mr1_reg[DPFD_TERMINATION_STROBE_BIT];
  assign fifo_in_valid = (state_reg == DPFD_WBURST) && dqs_edge &&
    (termination_strobe_en || !mask_s);
  dpfd_fifo #(
    .WIDTH(FW),
    .DEPTH(DPFD_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data({bank_reg, col_reg, 1'b0, dq_s}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_wr_out_ready && !o_wr_out_valid),
    .o_out_data(fifo_out)
  );

  // Output stage for write data towards the array
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_wr_out_valid <= 1'b0;
      o_wr_out_data <= '0;
      o_wr_out_col <= '0;
      o_wr_out_bank <= '0;
    end else if (i_ce) begin
      if (fifo_out_valid && i_wr_out_ready && !o_wr_out_valid) begin
        o_wr_out_valid <= 1'b1;
        o_wr_out_data <= fifo_out[DPFD_DQ_W-1:0];
        o_wr_out_col <= fifo_out[DPFD_FIFO_W +: DPFD_COL_W];
        o_wr_out_bank <= fifo_out[FW-1 -: DPFD_BANK_W];
      end else begin
        o_wr_out_valid <= 1'b0;
      end
    end
  end

  // Read drive: strobe toggles with each data change
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || (i_ce && !rst_n_s)) begin
      o_dq_out <= '0;
      o_dq_oe <= 1'b0;
      o_dqs_out <= 1'b0;
      o_dqs_n_out <= 1'b1;
      o_dqs_oe <= 1'b0;
      o_rd_data_ready <= 1'b0;
    end else if (i_ce) begin
      o_rd_data_ready <= 1'b0;
      if (state_reg == DPFD_RBURST && (ck_rise || dqs_edge)) begin
        o_dq_out <= i_rd_data;
        o_dqs_out <= !o_dqs_out;
        o_dqs_n_out <= o_dqs_out;
        o_dq_oe <= 1'b1;
        o_dqs_oe <= 1'b1;
        o_rd_data_ready <= 1'b1;
      end else if (state_reg != DPFD_RBURST) begin
        o_dq_oe <= 1'b0;
        o_dqs_oe <= 1'b0;
        o_dqs_out <= 1'b0;
        o_dqs_n_out <= 1'b1;
      end
    end
  end

  // Termination enables; input-only pins have none
  logic rtt_off;
  logic odt_on;
  assign rtt_off = !(mr1_reg[DPFD_MR1_RTT_B0] || mr1_reg[DPFD_MR1_RTT_B1] ||
    mr1_reg[DPFD_MR1_RTT_B2]) &&
    !(mr2_reg[DPFD_MR2_RTT_LO] || mr2_reg[DPFD_MR2_RTT_HI]);
  assign odt_on = dev_on && odt_s && !rtt_off && !o_dq_oe;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || (i_ce && !rst_n_s)) begin
      o_odt_dq_en <= 1'b0;
      o_odt_dqs_en <= 1'b0;
      o_odt_mask_en <= 1'b0;
      o_odt_termination_strobe_n_en <= 1'b0;
      o_termination_strobe_mode <= 1'b0;
    end else if (i_ce) begin
      o_odt_dq_en <= odt_on;
      o_odt_dqs_en <= odt_on;
      o_odt_mask_en <= odt_on;
      o_odt_termination_strobe_n_en <= odt_on && termination_strobe_en;
      o_termination_strobe_mode <= termination_strobe_en;
    end
  end

  // Status mirrors
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_bank_open <= '0;
      o_mode_register_one <= DPFD_MR_RESET;
      o_mode_register_two <= DPFD_MR_RESET;
      o_mode_register_other <= DPFD_MR_RESET;
      o_burst_chop <= 1'b0;
      o_auto_precharge <= 1'b0;
      o_busy <= 1'b0;
      for (int i = 0; i < DPFD_NBANK; i++) begin
        o_open_row[i] <= '0;
      end
    end else if (i_ce) begin
      o_bank_open <= open_reg;
      o_mode_register_one <= mr1_reg;
      o_mode_register_two <= mr2_reg;
      o_mode_register_other <= mro_reg;
      o_burst_chop <= chop_reg;
      o_auto_precharge <= ap_pend_reg;
      o_busy <= (state_reg != DPFD_IDLE);
      for (int i = 0; i < DPFD_NBANK; i++) begin
        o_open_row[i] <= row_reg[i];
      end
    end
  end

  // Checks, all on the system clock
  default clocking cb_chk @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence wr_cmd_s;
    i_ce && cmd == DPFD_CMD_WR && state_reg == DPFD_IDLE;
  endsequence
  masked_beat_drop_a: assert property (
    (state_reg == DPFD_WBURST && dqs_edge && mask_s && !termination_strobe_en)
      |-> !fifo_in_valid)
    else $error("masked beat accepted");
  cs_mask_cmd_a: assert property (
    cs_n_s |-> cmd == DPFD_CMD_NONE)
    else $error("command decoded with select high");
  chop_capture_a: assert property (
    wr_cmd_s |=> chop_reg == $past(!a_s[DPFD_BC_BIT]))
    else $error("burst chop not captured");
  bank_activate_a: assert property (
    (i_ce && rst_n_s && cmd == DPFD_CMD_ACT) |=> open_reg[$past(ba_s)])
    else $error("activate did not open bank");
  precharge_all_a: assert property (
    (i_ce && cmd == DPFD_CMD_PRE && a_s[DPFD_AP_BIT]) |=> open_reg == '0)
    else $error("precharge all left a bank open");
  mrs_load_a: assert property (
    (i_ce && rst_n_s && cmd == DPFD_CMD_MRS && ba_s == DPFD_MR1_SEL)
      |=> mr1_reg == $past(a_s))
    else $error("mode register one not loaded");
  rtt_ignore_a: assert property (
    (i_ce && rtt_off) |=> !o_odt_dq_en)
    else $error("termination on while disabled");
  termination_strobe_term_a: assert property (
    (i_ce && !termination_strobe_en) |=> !o_odt_termination_strobe_n_en)
    else $error("strobe pin terminated in mask mode");
  dqs_pair_a: assert property (
    o_dqs_oe |-> o_dqs_out != o_dqs_n_out)
    else $error("strobe pair not complementary");
endmodule : dpfd_decode
`default_nettype wire

// File: dpfd_pkg.sv
// Constants and types for the DRAM pin function decoder
package dpfd_pkg;
  localparam int DPFD_ADDR_W = 16;
  localparam int DPFD_BANK_W = 3;
  localparam int DPFD_NBANK = 8;
  localparam int DPFD_DQ_W = 8;
  localparam int DPFD_COL_W = 10;
  localparam int DPFD_FIFO_DEPTH = 16;
  localparam int DPFD_FIFO_W = 9;
  localparam int DPFD_AP_BIT = 10;
  localparam int DPFD_BC_BIT = 12;
  localparam int DPFD_TERMINATION_STROBE_BIT = 11;
  // Termination select fields in mode registers one and two
  localparam int DPFD_MR1_RTT_B0 = 2;
  localparam int DPFD_MR1_RTT_B1 = 6;
  localparam int DPFD_MR1_RTT_B2 = 9;
  localparam int DPFD_MR2_RTT_LO = 9;
  localparam int DPFD_MR2_RTT_HI = 10;
  localparam logic [DPFD_BANK_W-1:0] DPFD_MR0_SEL = 3'h0;
  localparam logic [DPFD_BANK_W-1:0] DPFD_MR1_SEL = 3'h1;
  localparam logic [DPFD_BANK_W-1:0] DPFD_MR2_SEL = 3'h2;
  localparam logic [DPFD_BANK_W-1:0] DPFD_MR3_SEL = 3'h3;
  localparam logic [DPFD_ADDR_W-1:0] DPFD_MR_RESET = 16'h0000;
  localparam logic [DPFD_NBANK-1:0] DPFD_ALL_BANKS = 8'hFF;
  // Command code {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] DPFD_CODE_MRS = 3'h0;
  localparam logic [2:0] DPFD_CODE_REF = 3'h1;
  localparam logic [2:0] DPFD_CODE_PRE = 3'h2;
  localparam logic [2:0] DPFD_CODE_ACT = 3'h3;
  localparam logic [2:0] DPFD_CODE_WR = 3'h4;
  localparam logic [2:0] DPFD_CODE_RD = 3'h5;
  localparam logic [2:0] DPFD_CODE_ZQ = 3'h6;
  localparam logic [2:0] DPFD_CODE_NOP = 3'h7;
  localparam logic [3:0] DPFD_BEATS_FULL = 4'h8;
  localparam logic [3:0] DPFD_BEATS_CHOP = 4'h4;
  typedef enum logic [3:0] {
    DPFD_CMD_NONE, DPFD_CMD_MRS, DPFD_CMD_REF, DPFD_CMD_PRE, DPFD_CMD_ACT,
    DPFD_CMD_WR, DPFD_CMD_RD, DPFD_CMD_ZQ, DPFD_CMD_NOP
  } dpfd_cmd_t;
  typedef enum {DPFD_IDLE, DPFD_WBURST, DPFD_RBURST} dpfd_state_t;
endpackage : dpfd_pkg

// File: dpfd_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dpfd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Handshake terms, full and empty from the count
  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rptr_reg];
  assign push = i_ce && i_in_valid && o_in_ready;
  assign pop = i_ce && o_out_valid && i_out_ready;

  // Storage write
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= i_in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    count_reg <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule : dpfd_fifo
`default_nettype wire

// File: dpfd_ctl_model.sv
// Controller-side model: link clock, command pins and write bursts
`timescale 1ns/1ps
`default_nettype none
module dpfd_ctl_model (
  input wire logic i_clk,
  output logic o_ck,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [2:0] o_bank_select,
  output logic [15:0] o_addr,
  output logic o_dqs,
  output logic o_dqs_n,
  output logic [7:0] o_dq,
  output logic o_write_byte_mask,
  output logic o_dram_reset_n
);
  // Free-running link clock, unrelated in phase to i_clk
  initial begin
    o_ck = 1'b0;
    forever #62.5 o_ck = ~o_ck;
  end
  // Idle levels; strobe pair always complementary
  initial begin
    o_cke = 1'b1;
    o_dram_reset_n = 1'b1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_bank_select = 3'h0;
    o_addr = 16'h0000;
    o_dqs = 1'b0;
    o_dqs_n = 1'b1;
    o_dq = 8'h00;
    o_write_byte_mask = 1'b0;
  end
  // One command held across a link clock rise, then deselect
  task automatic cmd(input logic cs_n, input logic [2:0] code,
      input logic [2:0] ba, input logic [15:0] a);
    @(negedge o_ck);
    @(posedge i_clk) #1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = {cs_n, code};
    o_bank_select = ba;
    o_addr = a;
    @(negedge o_ck);
    @(posedge i_clk) #1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_bank_select = ~ba;
    o_addr = ~a;
    repeat (6) @(posedge i_clk);
    #1;
  endtask
  // Write beats; strobe toggles mid-beat, mask travels with beat
  task automatic wr_burst(input logic [3:0] n, input logic [7:0] base,
      input logic [7:0] mpat);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk) #1;
      o_dq = base + 8'(i);
      o_write_byte_mask = mpat[i];
      repeat (4) @(posedge i_clk);
      #1;
      o_dqs = ~o_dqs;
      o_dqs_n = ~o_dqs_n;
      repeat (4) @(posedge i_clk);
    end
    #1;
    o_dq = ~o_dq;
    o_write_byte_mask = ~o_write_byte_mask;
  endtask
  // Reset pin pulse
  task automatic pulse_reset();
    @(posedge i_clk) #1;
    o_dram_reset_n = 1'b0;
    repeat (10) @(posedge i_clk);
    #1;
    o_dram_reset_n = 1'b1;
  endtask
endmodule // dpfd_ctl_model
`default_nettype wire

// File: tb_ddr3_pin_function_decode.sv
// Self-checking bench for the DRAM pin function decoder
`timescale 1ns/1ps
`default_nettype none
module tb_ddr3_pin_function_decode;
  import dpfd_pkg::*;
  typedef struct packed {
    logic [2:0] code;
    logic [2:0] ba;
    logic [15:0] a;
  } dpfd_row_t;
  localparam dpfd_row_t ROWS [7] = '{
    '{DPFD_CODE_MRS, 3'h1, 16'h0044}, '{DPFD_CODE_MRS, 3'h2, 16'h0000},
    '{DPFD_CODE_MRS, 3'h3, 16'h0004}, '{DPFD_CODE_MRS, 3'h0, 16'h1520},
    '{DPFD_CODE_ACT, 3'h0, 16'h1234}, '{DPFD_CODE_ACT, 3'h7, 16'hFFFF},
    '{DPFD_CODE_ACT, 3'h3, 16'h0001}};
  logic i_clk, i_reset_n, term, wr_ready;
  logic ck, cke, cs_n, ras_n, cas_n, we_n, dqs, dqs_n, mask, dram_rst_n;
  logic [2:0] ba;
  logic [15:0] addr, got;
  logic [7:0] dq, dq_out, bank_open;
  logic [15:0] open_row [DPFD_NBANK];
  logic [15:0] mr1, mr2, mro;
  logic wv, rdy, dq_oe, dqs_o, dqs_n_o, dqs_oe, odt_dq, odt_dqs, odt_m;
  logic odt_tn, termination_strobe, chop, ap, busy;
  logic [7:0] wd;
  logic [9:0] wc;
  logic [2:0] wb;
  logic [20:0] wq[$], exq[$];
  int num_errors = 0, n_tests = 0, rd_cnt = 0, cyc = 0;
  dpfd_ctl_model ctl (.i_clk(i_clk), .o_ck(ck), .o_cke(cke), .o_cs_n(cs_n),
    .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_bank_select(ba),
    .o_addr(addr), .o_dqs(dqs), .o_dqs_n(dqs_n), .o_dq(dq),
    .o_write_byte_mask(mask), .o_dram_reset_n(dram_rst_n));
  dpfd_decode dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1),
    .i_ck(ck), .i_dram_reset_n(dram_rst_n), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_bank_select(ba),
    .i_addr(addr), .i_termination_control(term), .i_dqs(dqs),
    .i_dqs_n(dqs_n), .i_dq(dq), .i_write_byte_mask(mask),
    .i_wr_out_ready(wr_ready), .o_wr_out_valid(wv), .o_wr_out_data(wd),
    .o_wr_out_col(wc), .o_wr_out_bank(wb), .i_rd_data(8'h5A),
    .o_rd_data_ready(rdy), .o_dq_out(dq_out), .o_dq_oe(dq_oe),
    .o_dqs_out(dqs_o), .o_dqs_n_out(dqs_n_o), .o_dqs_oe(dqs_oe),
    .o_odt_dq_en(odt_dq), .o_odt_dqs_en(odt_dqs), .o_odt_mask_en(odt_m),
    .o_odt_termination_strobe_n_en(odt_tn), .o_termination_strobe_mode(termination_strobe), .o_bank_open(bank_open),
    .o_open_row(open_row), .o_mode_register_one(mr1),
    .o_mode_register_two(mr2), .o_mode_register_other(mro),
    .o_burst_chop(chop), .o_auto_precharge(ap), .o_busy(busy));
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Output monitor and hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (wv === 1'b1 && wr_ready === 1'b1) wq.push_back({wb, wc, wd});
    if (rdy === 1'b1) rd_cnt++;
    if (dqs_oe === 1'b1 && dqs_o === dqs_n_o) begin
      num_errors++;
      $display("wrong value at %0t: strobe pair equal", $time);
    end
    if (cyc == 40000) begin
      num_errors++;
      $display("wrong value at %0t: timeout", $time);
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e,
      input string msg);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 400 && busy !== 1'b0; k++) @(posedge i_clk);
    chk(busy, 1'b0, "busy stuck");
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    i_reset_n = 1'b0;
    term = 1'b0;
    wr_ready = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    @(posedge i_clk) #1;
    chk({bank_open, dqs_n_o}, 9'h001, "reset state");
    foreach (ROWS[i]) begin
      ctl.cmd(1'b0, ROWS[i].code, ROWS[i].ba, ROWS[i].a);
      if (ROWS[i].code == DPFD_CODE_ACT) begin
        chk(bank_open[ROWS[i].ba], 1'b1, "bank open");
        chk(open_row[ROWS[i].ba], ROWS[i].a, "open row");
      end else begin
        got = (ROWS[i].ba == DPFD_MR1_SEL) ? mr1 :
          (ROWS[i].ba == DPFD_MR2_SEL) ? mr2 : mro;
        chk(got, ROWS[i].a, "mode register");
      end
    end
    // Termination enable, strobe option, disable
    term = 1'b1;
    repeat (8) @(posedge i_clk);
    chk({odt_dq, odt_dqs, odt_m, odt_tn}, 4'hE, "odt on");
    ctl.cmd(1'b0, DPFD_CODE_MRS, DPFD_MR1_SEL, 16'h0844);
    chk({termination_strobe, odt_dqs, odt_tn}, 3'h7, "term strobe");
    ctl.cmd(1'b0, DPFD_CODE_MRS, DPFD_MR1_SEL, 16'h0000);
    chk({odt_dq, odt_dqs, termination_strobe}, 3'h0, "odt ignored");
    term = 1'b0;
    // Deselected command does nothing
    ctl.cmd(1'b1, DPFD_CODE_ACT, 3'h5, 16'h0022);
    chk(bank_open[5], 1'b0, "deselected act");
    // Masked writes with sink stalled: full burst, then chop with precharge
    wr_ready = 1'b0;
    ctl.cmd(1'b0, DPFD_CODE_WR, 3'h3, 16'h1005);
    ctl.wr_burst(4'h8, 8'h10, 8'h24);
    wait_idle();
    chk(bank_open[3], 1'b1, "row left open");
    ctl.cmd(1'b0, DPFD_CODE_WR, 3'h3, 16'h0409);
    ctl.wr_burst(4'h4, 8'h40, 8'h02);
    wait_idle();
    chk(bank_open[3], 1'b0, "auto precharge");
    for (int i = 0; i < 8; i++) if (i != 2 && i != 5)
      exq.push_back({3'h3, 10'h005, 8'h10 + 8'(i)});
    for (int i = 0; i < 4; i++) if (i != 1)
      exq.push_back({3'h3, 10'h009, 8'h40 + 8'(i)});
    wr_ready = 1'b1;
    for (int k = 0; k < 100 && wq.size() < 9; k++) @(posedge i_clk);
    chk(wq.size(), 16'd9, "write beats kept");
    for (int i = 0; i < 9 && i < wq.size(); i++) begin
      chk({wq[i][20:18], wq[i][7:0]}, {exq[i][20:18], exq[i][7:0]},
        "write byte");
      if (i == 0 || i == 6) chk(wq[i][17:8], exq[i][17:8], "column");
    end
    // Full read burst
    ctl.cmd(1'b0, DPFD_CODE_ACT, 3'h1, 16'h0007);
    rd_cnt = 0;
    ctl.cmd(1'b0, DPFD_CODE_RD, 3'h1, 16'h1000);
    wait_idle();
    chk(rd_cnt, 16'd8, "read beats");
    chk({dq_out, chop, ap}, {8'h5A, 2'b00}, "read drive");
    // Single-bank then all-bank precharge
    ctl.cmd(1'b0, DPFD_CODE_PRE, 3'h0, 16'h0000);
    chk(bank_open, 8'h82, "one bank closed");
    ctl.cmd(1'b0, DPFD_CODE_PRE, 3'h0, 16'h0400);
    chk(bank_open, 8'h00, "all closed");
    // Reset pin clears mode registers
    ctl.pulse_reset();
    repeat (8) @(posedge i_clk);
    chk(mro, 16'h0000, "reset pin");
    wrap_up();
  end
endmodule // tb_ddr3_pin_function_decode
`default_nettype wire
